// ===== common/mqcp_pkg.sv
// Shared constants, types and decoders of the configuration port and queue bookkeeping
package mqcp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register sequence indices, in write and read order
   localparam logic [3:0] MQCP_IDX_OPTIONS = 4'h0;
   localparam logic [3:0] MQCP_IDX_Q1_LEN = 4'h1;
   localparam logic [3:0] MQCP_IDX_Q2_LEN = 4'h2;
   localparam logic [3:0] MQCP_IDX_CELL_LEN = 4'h3;
   localparam logic [3:0] MQCP_IDX_Q1_FILL = 4'h4;
   localparam logic [3:0] MQCP_IDX_LAST = 4'h9;
   localparam int unsigned MQCP_REG_COUNT = 10;

   // Implemented bits of each register on the 8-bit programming bus
   localparam logic [7:0] MQCP_MASK_OPTIONS_WR = 8'h1f;
   localparam logic [7:0] MQCP_MASK_OPTIONS_RD = 8'h0f;
   localparam logic [7:0] MQCP_MASK_Q1_LEN = 8'h1f;
   localparam logic [7:0] MQCP_MASK_Q2_LEN = 8'h0f;
   localparam logic [7:0] MQCP_MASK_CELL_LEN = 8'h3f;
   localparam logic [7:0] MQCP_MASK_THRESHOLD = 8'hff;

   // Option bit positions inside bus_options
   localparam int unsigned MQCP_OPT_OUT_WIDTH = 0;
   localparam int unsigned MQCP_OPT_OUT_STUFF = 1;
   localparam int unsigned MQCP_OPT_IN_WIDTH = 2;
   localparam int unsigned MQCP_OPT_IN_STUFF = 3;
   localparam int unsigned MQCP_OPT_IN_BIG_ENDIAN = 4;

   // Fixed low bits of the nine-bit thresholds
   localparam logic MQCP_FILL_LSB = 1'b1;
   localparam logic MQCP_DRAIN_LSB = 1'b0;

   localparam int unsigned MQCP_WORD_W = 18;

   ////////////////////////////////////////////////////////////////////////////////
   // Programming pins as seen after synchronisation
   typedef struct packed {
      logic strobe_n;
      logic rw;
      logic oe_n;
      logic request_n;
      logic [7:0] data;
   } mqcp_pin_t;

   localparam mqcp_pin_t MQCP_PIN_IDLE = 12'hb00;

   // One write-side word on its way to a queue
   typedef struct packed {
      logic [1:0] queue;
      logic abort;
      logic [MQCP_WORD_W-1:0] data;
   } mqcp_entry_t;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] mqcp_reg_mask(input logic [3:0] idx, input logic for_read);
      logic [7:0] mask;
      case (idx)
         MQCP_IDX_OPTIONS: mask = for_read ? MQCP_MASK_OPTIONS_RD : MQCP_MASK_OPTIONS_WR;
         MQCP_IDX_Q1_LEN: mask = MQCP_MASK_Q1_LEN;
         MQCP_IDX_Q2_LEN: mask = MQCP_MASK_Q2_LEN;
         MQCP_IDX_CELL_LEN: mask = MQCP_MASK_CELL_LEN;
         default: mask = (idx <= MQCP_IDX_LAST) ? MQCP_MASK_THRESHOLD : 8'h00;
      endcase
      return mask;
   endfunction : mqcp_reg_mask

   function automatic logic [1:0] mqcp_select_queue(input logic hi, input logic lo);
      return hi ? (lo ? 2'h2 : 2'h1) : 2'h0;
   endfunction : mqcp_select_queue

endpackage : mqcp_pkg

// ===== design/mqcp_fifo.sv
// Small write-side FIFO with registered full and empty flags
`timescale 1ns/10ps
module mqcp_fifo
   import mqcp_pkg::*;
#(
   parameter int unsigned WIDTH = 21,
   parameter int unsigned DEPTH = 4
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Filling side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Draining side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("mqcp_fifo depth must be a power of two of at least two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic in_ready;
      logic out_valid;
   } mqcp_fifo_state_t;

   mqcp_fifo_state_t st;
   mqcp_fifo_state_t next_st;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////////
   // Flags come from flops so neither side sees a combinational path through here
   always_comb
   begin
      next_st = st;
      push = i_in_valid && st.in_ready;
      pop = st.out_valid && i_out_ready;
      if (push)
      begin
         next_st.words[st.wr_ptr] = i_in_data;
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
      next_st.in_ready = next_st.count != (AW+1)'(DEPTH);
      next_st.out_valid = next_st.count != '0;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st <= '0;
         st.in_ready <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_in_ready = st.in_ready;
   assign o_out_valid = st.out_valid;
   assign o_out_data = st.words[st.rd_ptr];

endmodule : mqcp_fifo

// ===== design/mqcp_cfg_mem.sv
// Configuration register storage with registered read data
`timescale 1ns/10ps
module mqcp_cfg_mem
   import mqcp_pkg::*;
#(
   parameter int unsigned DEPTH = MQCP_REG_COUNT,
   parameter int unsigned WIDTH = 8,
   parameter int unsigned AW = 4
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Write port
   input wire logic i_wr_en,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   // Read port
   input wire logic [AW-1:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
);
   if (DEPTH > (1 << AW))
   begin : g_bad_size
      $error("mqcp_cfg_mem depth does not fit the address width");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0] rd;
   } mqcp_mem_state_t;

   mqcp_mem_state_t st;
   mqcp_mem_state_t next_st;

   always_comb
   begin
      next_st = st;
      if (i_wr_en && 32'(i_wr_addr) < DEPTH)
      begin
         next_st.words[i_wr_addr] = i_wr_data;
      end
      // Out-of-range addresses read as zero
      next_st.rd = (32'(i_rd_addr) < DEPTH) ? st.words[i_rd_addr] : '0;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_rd_data = st.rd;

endmodule : mqcp_cfg_mem

// ===== design/mqcp_config_port.sv
// Configuration programming port and three-queue cell bookkeeping
`timescale 1ns/10ps
//
// Contract
// - Programming bus driven only while output enable low and read selected.
// - Each strobe rising edge in read mode advances to next register.
// - After the tenth register, the next read returns bus_options again.
// - Unimplemented bus bits read back as zero.
// - Write order options, lengths, cell length, six thresholds, all low-aligned.
// - Reads follow write order; bus_options shows only its low four bits.
// - Byte output: cell-ready drops on first byte if stuffing, else last.
// - Select high/low reads queue 2, both high queue 3, if cell ready.
// - Blocked read on a newly selected queue outputs its held word.
// - Abort with a queue's write enable discards its unconfirmed words.
// - Cells complete into whichever queue's write enable is active.
// - Writes on strobe fall with owner ready low and write selected; ten max.
// - Bus request low drops input owner ready after two clock edges.
// - Fill thresholds are nine bits with a fixed one as LSB.
// - Drain thresholds are nine bits with a fixed zero as LSB.
module mqcp_config_port
   import mqcp_pkg::*;
#(
   parameter int unsigned CELLS_MAX = 8,
   parameter int unsigned FIFO_DEPTH = 4
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Programming pins
   input wire logic i_program_strobe_n,
   input wire logic i_program_read_select,
   input wire logic i_program_output_enable_n,
   input wire logic i_program_bus_request_n,
   input wire logic [7:0] i_program_bus,
   output logic [7:0] o_program_bus,
   output logic o_program_bus_oe,
   output logic o_input_owner_ready,
   output logic o_config_done,
   // Write side
   input wire logic i_queue1_write_enable,
   input wire logic i_queue2_write_enable,
   input wire logic i_queue3_write_enable,
   input wire logic i_cell_abort,
   input wire logic [MQCP_WORD_W-1:0] i_write_data,
   output logic o_write_ready,
   // Read side
   input wire logic i_read_enable,
   input wire logic i_queue_select_lo,
   input wire logic i_queue_select_hi,
   output logic [MQCP_WORD_W-1:0] o_read_data,
   output logic o_queue1_cell_ready,
   output logic o_queue2_cell_ready,
   output logic o_queue3_cell_ready,
   output logic [2:0] o_queue_level_flag
);
   localparam int unsigned CW = $clog2(CELLS_MAX + 1);
   localparam int unsigned PIN_W = $bits(mqcp_pin_t);
   localparam int unsigned ENTRY_W = $bits(mqcp_entry_t);

   if (CELLS_MAX < 1 || CW > 9)
   begin : g_bad_cells
      $error("mqcp_config_port cell count must be between 1 and 511");
   end

   typedef struct packed {
      mqcp_pin_t s1;
      mqcp_pin_t s2;
      mqcp_pin_t s3;
      mqcp_pin_t pins;
      logic strobe_d;
      logic req_dly;
      logic owner_ready;
      logic [3:0] wr_ptr;
      logic cfg_done;
      logic [3:0] rd_ptr;
      logic [3:0] rd_shown;
      logic [7:0] bus_out;
      logic bus_oe;
      logic [4:0] options;
      logic [5:0] cell_len;
      logic [2:0][7:0] fill_thr;
      logic [2:0][7:0] drain_thr;
      logic [2:0][5:0] pend;
      logic [2:0][5:0] rd_word;
      logic [2:0][CW-1:0] cells;
      logic [2:0][MQCP_WORD_W-1:0] latest;
      logic [2:0][MQCP_WORD_W-1:0] held;
      logic [2:0] cell_ready;
      logic [2:0] level_flag;
      logic byte_phase;
      logic [1:0] sel_q;
      logic [MQCP_WORD_W-1:0] rd_data;
   } mqcp_state_t;

   mqcp_state_t st;
   mqcp_state_t next_st;
   mqcp_pin_t pins_now;
   logic [PIN_W-1:0] agree;
   logic strobe_rise;
   logic strobe_fall;
   logic cfg_we;
   logic [7:0] cfg_wdata;
   logic [7:0] mem_rd;
   logic [3:0] tix;
   mqcp_entry_t in_entry;
   mqcp_entry_t out_entry;
   logic [ENTRY_W-1:0] out_raw;
   logic in_valid;
   logic out_valid;
   logic out_ready;
   logic take;
   logic [1:0] dq;
   logic [1:0] rq;
   logic rd_go;
   logic byte_mode;
   logic stuff;
   logic last_word;
   logic word_done;
   logic cell_done;
   logic [2:0] inc;
   logic [2:0] dec;

   ////////////////////////////////////////////////////////////////////////////////
   // Write-side entry: lowest numbered enable wins if several are raised
   assign pins_now = '{strobe_n: i_program_strobe_n, rw: i_program_read_select,
                       oe_n: i_program_output_enable_n, request_n: i_program_bus_request_n,
                       data: i_program_bus};
   assign in_valid = st.owner_ready &&
                     (i_queue1_write_enable || i_queue2_write_enable || i_queue3_write_enable);
   assign in_entry = '{queue: i_queue1_write_enable ? 2'h0 : (i_queue2_write_enable ? 2'h1 : 2'h2),
                       abort: i_cell_abort, data: i_write_data};
   assign out_entry = mqcp_entry_t'(out_raw);

   mqcp_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(in_valid),
      .o_in_ready(o_write_ready),
      .i_in_data(ENTRY_W'(in_entry)),
      .o_out_valid(out_valid),
      .i_out_ready(out_ready),
      .o_out_data(out_raw)
   );

   mqcp_cfg_mem #(
      .DEPTH(MQCP_REG_COUNT),
      .WIDTH(8),
      .AW(4)
   ) u_mem (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_wr_en(cfg_we),
      .i_wr_addr(st.wr_ptr),
      .i_wr_data(cfg_wdata),
      .i_rd_addr(st.rd_ptr),
      .o_rd_data(mem_rd)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      inc = 3'h0;
      dec = 3'h0;

      // Pins pass three stages; a bit moves only when stages two and three agree
      next_st.s1 = pins_now;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      agree = st.s2 ~^ st.s3;
      next_st.pins = mqcp_pin_t'((st.s2 & agree) | (st.pins & ~agree));
      next_st.strobe_d = st.pins.strobe_n;
      strobe_rise = st.pins.strobe_n && !st.strobe_d;
      strobe_fall = !st.pins.strobe_n && st.strobe_d;

      // Two edges from a settled request to the ownership change
      next_st.req_dly = st.pins.request_n;
      next_st.owner_ready = st.req_dly;

      // Configuration writes; the sequence locks after the tenth
      cfg_we = strobe_fall && !st.owner_ready && !st.pins.rw && !st.cfg_done;
      cfg_wdata = st.pins.data & mqcp_reg_mask(st.wr_ptr, 1'b0);
      tix = st.wr_ptr - MQCP_IDX_Q1_FILL;
      if (cfg_we)
      begin
         if (st.wr_ptr == MQCP_IDX_LAST)
         begin
            next_st.cfg_done = 1'b1;
         end
         else
         begin
            next_st.wr_ptr = st.wr_ptr + 4'h1;
         end
         if (st.wr_ptr == MQCP_IDX_OPTIONS)
         begin
            next_st.options = cfg_wdata[4:0];
         end
         else if (st.wr_ptr == MQCP_IDX_CELL_LEN)
         begin
            next_st.cell_len = cfg_wdata[5:0];
         end
         else if (st.wr_ptr >= MQCP_IDX_Q1_FILL)
         begin
            if (tix[0])
            begin
               next_st.drain_thr[tix[2:1]] = cfg_wdata;
            end
            else
            begin
               next_st.fill_thr[tix[2:1]] = cfg_wdata;
            end
         end
      end

      // Readback walks the same sequence and wraps to bus_options
      if (strobe_rise && st.pins.rw)
      begin
         next_st.rd_ptr = (st.rd_ptr == MQCP_IDX_LAST) ? MQCP_IDX_OPTIONS
                                                       : st.rd_ptr + 4'h1;
      end
      next_st.rd_shown = st.rd_ptr;
      next_st.bus_out = mem_rd & mqcp_reg_mask(st.rd_shown, 1'b1);
      next_st.bus_oe = !st.pins.oe_n && st.pins.rw;

      // Drain stalls on a full queue, so the FIFO fills and back-pressures writers
      dq = out_entry.queue;
      out_ready = st.cfg_done && st.cells[dq] != CW'(CELLS_MAX);
      take = out_valid && out_ready;
      if (take)
      begin
         if (out_entry.abort)
         begin
            next_st.pend[dq] = 6'h00;
         end
         else
         begin
            next_st.latest[dq] = out_entry.data;
            if (st.pend[dq] + 6'h01 == st.cell_len)
            begin
               next_st.pend[dq] = 6'h00;
               inc[dq] = 1'b1;
            end
            else
            begin
               next_st.pend[dq] = st.pend[dq] + 6'h01;
            end
         end
      end

      // Read side
      rq = mqcp_select_queue(i_queue_select_hi, i_queue_select_lo);
      rd_go = i_read_enable && st.cell_ready[rq];
      byte_mode = st.options[MQCP_OPT_OUT_WIDTH];
      stuff = st.options[MQCP_OPT_OUT_STUFF];
      last_word = st.rd_word[rq] == st.cell_len - 6'h01;
      word_done = !byte_mode || st.byte_phase || (stuff && last_word);
      cell_done = last_word && (!byte_mode || (stuff ? !st.byte_phase : st.byte_phase));
      next_st.sel_q = rq;
      if (rd_go)
      begin
         if (!byte_mode || !st.byte_phase)
         begin
            next_st.held[rq] = st.latest[rq];
            next_st.rd_data = st.latest[rq];
         end
         else
         begin
            next_st.rd_data = {st.held[rq][8:0], st.held[rq][17:9]};
         end
         next_st.byte_phase = byte_mode && !word_done;
         if (word_done)
         begin
            next_st.rd_word[rq] = cell_done ? 6'h00 : st.rd_word[rq] + 6'h01;
         end
         dec[rq] = cell_done;
      end
      else if (rq != st.sel_q)
      begin
         // Switching without a read shows what the new queue last presented
         next_st.rd_data = st.held[rq];
      end

      for (int k = 0; k < 3; k++)
      begin
         next_st.cells[k] = st.cells[k] + CW'(inc[k]) - CW'(dec[k]);
         next_st.cell_ready[k] = next_st.cells[k] != '0;
         if (9'(next_st.cells[k]) >= {st.fill_thr[k], MQCP_FILL_LSB})
         begin
            next_st.level_flag[k] = 1'b0;
         end
         else if (9'(next_st.cells[k]) <= {st.drain_thr[k], MQCP_DRAIN_LSB})
         begin
            next_st.level_flag[k] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pointers start at the first register after every reset
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st <= '0;
         st.s1 <= MQCP_PIN_IDLE;
         st.s2 <= MQCP_PIN_IDLE;
         st.s3 <= MQCP_PIN_IDLE;
         st.pins <= MQCP_PIN_IDLE;
         st.strobe_d <= 1'b1;
         st.req_dly <= 1'b1;
         st.owner_ready <= 1'b1;
         st.level_flag <= 3'h7;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_program_bus = st.bus_out;
   assign o_program_bus_oe = st.bus_oe;
   assign o_input_owner_ready = st.owner_ready;
   assign o_config_done = st.cfg_done;
   assign o_read_data = st.rd_data;
   assign o_queue1_cell_ready = st.cell_ready[0];
   assign o_queue2_cell_ready = st.cell_ready[1];
   assign o_queue3_cell_ready = st.cell_ready[2];
   assign o_queue_level_flag = st.level_flag;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_bus_drive_gate:
      assert property (st.pins.oe_n || !st.pins.rw |=> !o_program_bus_oe)
      else $error("programming bus driven without read and output enable");

   a_read_advance:
      assert property (strobe_rise && st.pins.rw && st.rd_ptr != MQCP_IDX_LAST
                       |=> st.rd_ptr == $past(st.rd_ptr) + 4'h1 ##2 st.rd_shown == $past(st.rd_ptr, 2))
      else $error("read pointer did not advance on strobe rise");

   a_read_wrap:
      assert property (strobe_rise && st.pins.rw && st.rd_ptr == MQCP_IDX_LAST
                       |=> st.rd_ptr == MQCP_IDX_OPTIONS)
      else $error("read pointer did not wrap to first register");

   a_unused_zero:
      assert property (1'b1 |=> (o_program_bus & ~mqcp_reg_mask($past(st.rd_shown), 1'b1)) == 8'h00)
      else $error("unimplemented bit read back as one");

   a_options_four:
      assert property (st.rd_shown == MQCP_IDX_OPTIONS |=> o_program_bus[7:4] == 4'h0)
      else $error("bus_options readback wider than four bits");

   a_write_order:
      assert property (cfg_we && st.wr_ptr != MQCP_IDX_LAST |=> st.wr_ptr == $past(st.wr_ptr) + 4'h1)
      else $error("configuration write pointer out of sequence");

   a_config_lock:
      assert property (st.cfg_done |=> st.cfg_done && $stable(st.options) && $stable(st.cell_len))
      else $error("configuration changed after the tenth write");

   a_request_owner:
      assert property ($fell(st.pins.request_n) |-> ##2 !o_input_owner_ready)
      else $error("owner ready not low two edges after bus request");

   a_cell_drop:
      assert property (rd_go && byte_mode && stuff && last_word && !st.byte_phase
                       && st.cells[rq] == CW'(1) && !inc[rq] |=> !st.cell_ready[$past(rq)])
      else $error("cell ready not dropped on first byte of last word");

   a_select_read:
      assert property (rd_go && rq == 2'h2 && !byte_mode |=> o_read_data == $past(st.latest[2]))
      else $error("third queue not read when both selects high");

   a_switch_hold:
      assert property (!rd_go && rq != st.sel_q |=> o_read_data == $past(st.held[rq]))
      else $error("blocked switch did not show the held word");

   a_abort_clear:
      assert property (take && out_entry.abort |=> st.pend[$past(dq)] == 6'h00)
      else $error("abort left unconfirmed words in the queue");

   a_fill_odd:
      assert property (9'(st.cells[0]) >= {st.fill_thr[0], MQCP_FILL_LSB} |-> !st.level_flag[0])
      else $error("level flag high at or above fill threshold");

   a_drain_even:
      assert property (9'(st.cells[1]) <= {st.drain_thr[1], MQCP_DRAIN_LSB}
                       && 9'(st.cells[1]) < {st.fill_thr[1], MQCP_FILL_LSB} |-> st.level_flag[1])
      else $error("level flag low at or below drain threshold");

endmodule : mqcp_config_port

// ===== dv/mqcp_ctrl_model.sv
// Behavioural controller that drives the programming pins
`timescale 1ns/10ps
module mqcp_ctrl_model
(
   // Clock
   input wire logic i_clk,
   // Programming pins
   output logic o_strobe_n,
   output logic o_read_select,
   output logic o_output_enable_n,
   output logic o_request_n,
   output logic [7:0] o_data
);
   initial
   begin
      o_strobe_n = 1'b1;
      o_read_select = 1'b0;
      o_output_enable_n = 1'b1;
      o_request_n = 1'b1;
      o_data = 8'h00;
   end
   ////////////////////////////////////////////////////////////
   // Strobe stays low six cycles and high at least fifteen so the pin filter sees each level
   task automatic pulse(input logic [7:0] d);
      @(negedge i_clk);
      o_data = d;
      repeat (4) @(negedge i_clk);
      o_strobe_n = 1'b0;
      repeat (6) @(negedge i_clk);
      o_strobe_n = 1'b1;
      repeat (10) @(negedge i_clk);
   endtask : pulse
   task automatic pins(input logic rd, input logic oe_n, input logic req_n);
      @(negedge i_clk);
      o_read_select = rd;
      o_output_enable_n = oe_n;
      o_request_n = req_n;
      repeat (10) @(negedge i_clk);
   endtask : pins
endmodule : mqcp_ctrl_model

// ===== dv/test_mqcp_config_port.sv
// Self-checking bench of the configuration port and queue bookkeeping
`timescale 1ns/10ps
module test_mqcp_config_port;
   logic i_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] q_en = 3'h0;
   logic abort = 1'b0;
   logic [17:0] wdata = 18'h0;
   logic rd_en = 1'b0;
   logic sel_hi = 1'b0;
   logic sel_lo = 1'b0;
   wire logic s_n, rd, oe_n, req_n, oe, own, done, wr_rdy, cr1, cr2, cr3;
   wire logic [7:0] c_data, d_bus, p_wire;
   wire logic [17:0] rdata;
   wire logic [2:0] lvl;
   int mismatches = 0;
   int total_checks = 0;
   // Queue 1 fill threshold of zero makes its level flag drop at the first cell
   logic [7:0] wv [10] = '{8'hfa, 8'hf3, 8'h37, 8'hc2, 8'h00, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
   logic [7:0] rm [10] = '{8'h0f, 8'h1f, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
   // Released wire shows a toggling pattern, never the last value
   assign p_wire = oe ? d_bus : (rd ? (8'ha5 ^ {8{i_clk}}) : c_data);
   initial
   begin
      forever #12.5 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////
   mqcp_ctrl_model u_mqcp_ctrl_model (.i_clk(i_clk), .o_strobe_n(s_n), .o_read_select(rd),
      .o_output_enable_n(oe_n), .o_request_n(req_n), .o_data(c_data));
   mqcp_config_port u_mqcp_config_port (.i_clk(i_clk), .i_reset_n(rst_n),
      .i_program_strobe_n(s_n), .i_program_read_select(rd), .i_program_output_enable_n(oe_n),
      .i_program_bus_request_n(req_n), .i_program_bus(p_wire), .o_program_bus(d_bus),
      .o_program_bus_oe(oe), .o_input_owner_ready(own), .o_config_done(done),
      .i_queue1_write_enable(q_en[0]), .i_queue2_write_enable(q_en[1]),
      .i_queue3_write_enable(q_en[2]), .i_cell_abort(abort), .i_write_data(wdata),
      .o_write_ready(wr_rdy), .i_read_enable(rd_en), .i_queue_select_lo(sel_lo),
      .i_queue_select_hi(sel_hi), .o_read_data(rdata), .o_queue1_cell_ready(cr1),
      .o_queue2_cell_ready(cr2), .o_queue3_cell_ready(cr3), .o_queue_level_flag(lvl));
   ////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic put(input logic [2:0] en, input logic ab, input logic [17:0] d);
      @(negedge i_clk);
      q_en = en;
      abort = ab;
      wdata = d;
   endtask : put
   task automatic get(input logic hi, input logic lo, input logic en);
      @(negedge i_clk);
      sel_hi = hi;
      sel_lo = lo;
      rd_en = en;
      @(negedge i_clk);
      rd_en = 1'b0;
   endtask : get
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   task automatic test_fill;
      for (int i = 0; i < 4; i++) put(3'h1, 1'b0, 18'h100 + 18'(i));
      put(3'h0, 1'b0, 18'h0);
      @(negedge i_clk);
      check("write_ready", 1'b0, wr_rdy);
      $display("test_fill done");
   endtask : test_fill
   task automatic test_config;
      u_mqcp_ctrl_model.pins(1'b0, 1'b1, 1'b0);
      check("owner_ready", 1'b0, own);
      for (int i = 0; i < 10; i++) u_mqcp_ctrl_model.pulse(wv[i]);
      check("config_done", 1'b1, done);
      u_mqcp_ctrl_model.pulse(8'h99);
      u_mqcp_ctrl_model.pins(1'b0, 1'b1, 1'b1);
      check("owner_back", 1'b1, own);
      $display("test_config done");
   endtask : test_config
   task automatic test_readback;
      check("oe_write", 1'b0, oe);
      u_mqcp_ctrl_model.pins(1'b1, 1'b1, 1'b1);
      check("oe_off", 1'b0, oe);
      u_mqcp_ctrl_model.pins(1'b1, 1'b0, 1'b1);
      check("oe_on", 1'b1, oe);
      check("reg0", wv[0] & rm[0], p_wire);
      for (int i = 1; i <= 10; i++)
      begin
         u_mqcp_ctrl_model.pulse(8'h00);
         check("reg", wv[i % 10] & rm[i % 10], p_wire);
      end
      u_mqcp_ctrl_model.pins(1'b0, 1'b1, 1'b1);
      check("oe_end", 1'b0, oe);
      $display("test_readback done");
   endtask : test_readback
   task automatic test_queues;
      check("cr1", 1'b1, cr1);
      check("level_fill", 3'h6, lvl);
      for (int i = 0; i < 4; i++) get(1'b0, 1'b0, 1'b1);
      check("q1_data", 18'h103, rdata);
      check("cr1_low", 1'b0, cr1);
      check("level_drain", 3'h7, lvl);
      put(3'h2, 1'b0, 18'h200);
      put(3'h2, 1'b0, 18'h201);
      put(3'h0, 1'b0, 18'h0);
      repeat (12) @(negedge i_clk);
      check("cr2", 1'b1, cr2);
      check("cr1_q2", 1'b0, cr1);
      get(1'b1, 1'b0, 1'b1);
      get(1'b1, 1'b0, 1'b1);
      check("q2_data", 18'h201, rdata);
      get(1'b0, 1'b0, 1'b0);
      check("held_q1", 18'h103, rdata);
      put(3'h4, 1'b0, 18'h300);
      put(3'h4, 1'b1, 18'h0);
      put(3'h4, 1'b0, 18'h301);
      put(3'h0, 1'b0, 18'h0);
      repeat (12) @(negedge i_clk);
      check("cr3_abort", 1'b0, cr3);
      put(3'h4, 1'b0, 18'h302);
      put(3'h0, 1'b0, 18'h0);
      repeat (12) @(negedge i_clk);
      check("cr3", 1'b1, cr3);
      get(1'b1, 1'b1, 1'b1);
      get(1'b1, 1'b1, 1'b1);
      check("q3_data", 18'h302, rdata);
      $display("test_queues done");
   endtask : test_queues
   // Second reset, then byte-wide output with stuffing on a two-word cell
   task automatic test_bytes;
      @(negedge i_clk);
      rst_n = 1'b0;
      repeat (6) @(negedge i_clk);
      rst_n = 1'b1;
      check("done_reset", 1'b0, done);
      u_mqcp_ctrl_model.pins(1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 10; i++) u_mqcp_ctrl_model.pulse(i == 0 ? 8'h03 : wv[i]);
      u_mqcp_ctrl_model.pins(1'b0, 1'b1, 1'b1);
      put(3'h1, 1'b0, 18'h00100);
      put(3'h1, 1'b0, 18'h001ff);
      put(3'h0, 1'b0, 18'h0);
      repeat (12) @(negedge i_clk);
      check("cr1_bytes", 1'b1, cr1);
      get(1'b0, 1'b0, 1'b1);
      check("byte_first", 18'h001ff, rdata);
      get(1'b0, 1'b0, 1'b1);
      check("byte_swap", 18'h3fe00, rdata);
      get(1'b0, 1'b0, 1'b1);
      check("cr1_stuff", 1'b0, cr1);
      $display("test_bytes done");
   endtask : test_bytes
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(negedge i_clk);
      rst_n = 1'b1;
      @(negedge i_clk);
      test_fill();
      test_config();
      test_readback();
      test_queues();
      test_bytes();
      report_and_stop();
   end
   initial
   begin
      #500000;
      mismatches++;
      report_and_stop();
   end
endmodule : test_mqcp_config_port
